// ---- bench/nvss_host.sv ----
// host model: issues decoded commands, chip select and sram writes toward the sequencer
`timescale 1ns/1ps
module nvss_host import nvss_pkg::*; (
  input wire logic sys_clk,
  input wire logic busy,
  output logic cs_n,
  output nvss_cmd_t cmd,
  output logic sram_write
);
  initial begin
    cs_n = 1'b0;
    cmd = '0;
    sram_write = 1'b0;
  end
  // ----------------------------------------
  // requests: commands and writes one cycle wide, chip select held as a level
  // ----------------------------------------
  // no command while the device reports busy, bounded wait; writes do not wait
  task automatic issue(input nvss_op_t op);
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge sys_clk);
    @(posedge sys_clk) #1;
    cmd = '{1'b1, op};
    @(posedge sys_clk) #1;
    cmd = '0;
  endtask
  task automatic write();
    @(posedge sys_clk) #1;
    sram_write = 1'b1;
    @(posedge sys_clk) #1;
    sram_write = 1'b0;
  endtask
  task automatic select(input logic v);
    @(posedge sys_clk) #1;
    cs_n = v;
  endtask
endmodule // nvss_host

// ---- bench/nvss_seq_test.sv ----
// self-checking testbench of the nonvolatile store/recall sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module nvss_seq_test import nvss_pkg::*;;
  localparam int RS = 20, ST = 30, RC = 25, SS = 20, SL = 20, WK = 20, SB = 20;
  logic sys_clk, rstn, clk_en, supply_ok, cs_n, sram_write, sram_enable, store_active, recall_active;
  nvss_cmd_t cmd;
  nvss_stat_t stat;
  int fail_count = 0;
  int check_count = 0;
  nvss_seq #(.RESTORE_CYCLES(RS), .STORE_CYCLES(ST), .RECALL_CYCLES(RC), .SOFTSEQ_CYCLES(SS),
    .SLEEP_CYCLES(SL), .WAKE_CYCLES(WK), .STANDBY_CYCLES(SB)) DUT (.sys_clk(sys_clk), .rstn(rstn),
    .clk_en(clk_en), .supply_ok(supply_ok), .cs_n(cs_n), .cmd(cmd), .sram_write(sram_write),
    .sram_enable(sram_enable), .store_active(store_active), .recall_active(recall_active), .stat(stat));
  nvss_host host (.sys_clk(sys_clk), .busy(stat.busy), .cs_n(cs_n), .cmd(cmd), .sram_write(sram_write));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // counts edges until the selected condition holds
  task automatic wait_cond(input int sel, input int max, output int n);
    for (n = 0; n < max; n++) begin
      @(posedge sys_clk) #1;
      if ((sel == 0 && stat.busy === 1'b0) || (sel == 1 && store_active === 1'b1) ||
          (sel == 2 && stat.asleep === 1'b1) || (sel == 3 && stat.standby === 1'b1) ||
          (sel == 4 && recall_active === 1'b0)) break;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_powerup();
    int n;
    repeat (3) @(posedge sys_clk);
    #1 `CHK(recall_active, 1'b1)
    `CHK(sram_enable, 1'b0)
    wait_cond(4, RS + 6, n);
    `CHK(n >= RS - 3 && n <= RS + 1, 1'b1)
    `CHK(sram_enable, 1'b1)
    $display("powerup done at %0t", $time);
  endtask
  // software store or recall with a write attempted in mid-operation
  task automatic t_nvop(input nvss_op_t op, input int t);
    int n;
    host.write();
    @(posedge sys_clk);
    #1 `CHK(stat.write_pending, 1'b1)
    host.issue(op);
    @(posedge sys_clk) #1;
    `CHK(stat.busy, 1'b1)
    `CHK(stat.access_inhibit_flag, 1'b1)
    repeat (SS) @(posedge sys_clk);
    #1 `CHK(sram_enable, 1'b1)
    repeat (4) @(posedge sys_clk);
    #1 `CHK(op == NVSS_OP_STORE ? store_active : recall_active, 1'b1)
    `CHK(sram_enable, 1'b0)
    host.write();
    wait_cond(0, t + 8, n);
    `CHK(n >= t - 8 && n <= t, 1'b1)
    repeat (2) @(posedge sys_clk);
    #1 `CHK(stat.write_pending, 1'b0)
    `CHK(sram_enable, 1'b1)
    `CHK(stat.access_inhibit_flag, 1'b0)
    $display("nv operation %0d done at %0t", op, $time);
  endtask
  task automatic t_save(input nvss_op_t op, input logic exp);
    int n;
    host.issue(op);
    wait_cond(0, SS + 10, n);
    `CHK(n >= SS && n <= SS + 4, 1'b1)
    repeat (2) @(posedge sys_clk);
    #1 `CHK(stat.power_loss_save, exp)
    $display("save mode %0d done at %0t", op, $time);
  endtask
  task automatic t_power_loss(input logic wr, input logic exp);
    int n;
    if (wr) host.write();
    @(posedge sys_clk) #1;
    supply_ok = 1'b0;
    wait_cond(1, 12, n);
    `CHK(store_active, exp)
    repeat (ST + 4) @(posedge sys_clk);
    #1 `CHK(sram_enable, 1'b0)
    supply_ok = 1'b1;
    repeat (RS + 8) @(posedge sys_clk);
    #1 `CHK(sram_enable, 1'b1)
    `CHK(stat.write_pending, 1'b0)
    $display("power loss done at %0t", $time);
  endtask
  task automatic t_sleep();
    int n;
    host.select(1'b1);
    host.write();
    host.issue(NVSS_OP_SLEEP);
    wait_cond(2, SS + ST + SL + 12, n);
    `CHK(stat.asleep, 1'b1)
    host.select(1'b0);
    repeat (WK + 6) @(posedge sys_clk);
    #1 `CHK(stat.asleep, 1'b0)
    `CHK(stat.busy, 1'b0)
    `CHK(stat.write_pending, 1'b0)
    $display("sleep done at %0t", $time);
  endtask
  task automatic t_standby();
    int n;
    host.select(1'b1);
    wait_cond(3, SB + 8, n);
    `CHK(n >= SB - 1 && n <= SB + 4, 1'b1)
    host.select(1'b0);
    repeat (4) @(posedge sys_clk);
    #1 `CHK(stat.standby, 1'b0)
    $display("standby done at %0t", $time);
  endtask
  // a command offered while the clock enable is low must not be taken
  task automatic t_freeze();
    @(posedge sys_clk) #1;
    clk_en = 1'b0;
    host.issue(NVSS_OP_STORE);
    repeat (4) @(posedge sys_clk);
    #1 `CHK(stat.busy, 1'b0)
    `CHK(store_active, 1'b0)
    clk_en = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK(stat.busy, 1'b0)
    $display("freeze done at %0t", $time);
  endtask
  initial begin
    rstn = 1'b0;
    supply_ok = 1'b1;
    clk_en = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 `CHK(stat, 6'h00)
    `CHK(sram_enable, 1'b0)
    rstn = 1'b1;
    t_powerup();
    t_nvop(NVSS_OP_STORE, ST);
    t_nvop(NVSS_OP_RECALL, RC);
    t_power_loss(1'b1, 1'b1);
    t_power_loss(1'b0, 1'b0);
    t_save(NVSS_OP_SAVE_DIS, 1'b0);
    t_power_loss(1'b1, 1'b0);
    t_save(NVSS_OP_SAVE_EN, 1'b1);
    t_sleep();
    t_standby();
    t_freeze();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end
endmodule // nvss_seq_test

// ---- rtl/nvss_pkg.sv ----
// package: timing constants, states and carrier types for the nv store/recall sequencer
package nvss_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned RESTORE_MS = 20;
  localparam int unsigned STORE_MS = 8;
  localparam int unsigned DELAY_NS = 25;
  localparam int unsigned RECALL_US = 600;
  localparam int unsigned SOFTSEQ_US = 500;
  localparam int unsigned SLEEP_MS = 8;
  localparam int unsigned WAKE_MS = 20;
  localparam int unsigned STANDBY_US = 100;
  localparam int unsigned CLK_NS = 1000 / CLK_MHZ;
  // shortest time rounds down, least one cycle
  localparam int unsigned RESTORE_CYC = RESTORE_MS * 1000 * CLK_MHZ;
  localparam int unsigned STORE_CYC = STORE_MS * 1000 * CLK_MHZ;
  localparam int unsigned DELAY_CYC = (DELAY_NS / CLK_NS) < 1 ? 1 : DELAY_NS / CLK_NS;
  localparam int unsigned RECALL_CYC = RECALL_US * CLK_MHZ;
  localparam int unsigned SOFTSEQ_CYC = SOFTSEQ_US * CLK_MHZ;
  localparam int unsigned SLEEP_CYC = SLEEP_MS * 1000 * CLK_MHZ;
  localparam int unsigned WAKE_CYC = WAKE_MS * 1000 * CLK_MHZ;
  localparam int unsigned STANDBY_CYC = STANDBY_US * CLK_MHZ;
  localparam int unsigned CNT_W = 22;

  typedef enum logic [3:0] {
    NVSS_RESTORE = 4'h0,
    NVSS_READY = 4'h1,
    NVSS_SEQ = 4'h2,
    NVSS_GRACE = 4'h3,
    NVSS_STORE = 4'h4,
    NVSS_RECALL = 4'h5,
    NVSS_GOSLEEP = 4'h6,
    NVSS_SLEEP = 4'h7,
    NVSS_WAKE = 4'h8,
    NVSS_POWERDN = 4'h9
  } nvss_state_t;

  typedef enum logic [2:0] {
    NVSS_OP_NONE = 3'h0,
    NVSS_OP_STORE = 3'h1,
    NVSS_OP_RECALL = 3'h2,
    NVSS_OP_SAVE_EN = 3'h3,
    NVSS_OP_SAVE_DIS = 3'h4,
    NVSS_OP_SLEEP = 3'h5,
    NVSS_OP_AUTO = 3'h6
  } nvss_op_t;

  // command strobe from the decoded serial interface
  typedef struct packed {
    logic valid;
    nvss_op_t op;
  } nvss_cmd_t;

  // status toward the serial interface
  typedef struct packed {
    logic busy;
    logic access_inhibit_flag;
    logic write_pending;
    logic power_loss_save;
    logic asleep;
    logic standby;
  } nvss_stat_t;
endpackage

// ---- rtl/nvss_seq.sv ----
// nonvolatile store/recall sequencer: power-up restore, power loss save, soft commands, sleep and standby
`timescale 1ns/1ps
module nvss_seq import nvss_pkg::*; #(
  parameter int unsigned RESTORE_CYCLES = RESTORE_CYC,
  parameter int unsigned STORE_CYCLES = STORE_CYC,
  parameter int unsigned RECALL_CYCLES = RECALL_CYC,
  parameter int unsigned SOFTSEQ_CYCLES = SOFTSEQ_CYC,
  parameter int unsigned SLEEP_CYCLES = SLEEP_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned STANDBY_CYCLES = STANDBY_CYC,
  parameter bit SAVE_DEFAULT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic supply_ok,
  input wire logic cs_n,
  input wire nvss_cmd_t cmd,
  input wire logic sram_write,
  output logic sram_enable,
  output logic store_active,
  output logic recall_active,
  output nvss_stat_t stat
);
  // every phase length must be non-zero and fit the shared counter
  if (RESTORE_CYCLES < 1 || STORE_CYCLES < 1 || RECALL_CYCLES < 1 || SOFTSEQ_CYCLES < 1 ||
      SLEEP_CYCLES < 1 || WAKE_CYCLES < 1 || STANDBY_CYCLES < 1 ||
      RESTORE_CYCLES >= (1 << CNT_W) || STORE_CYCLES >= (1 << CNT_W) || RECALL_CYCLES >= (1 << CNT_W) ||
      SOFTSEQ_CYCLES >= (1 << CNT_W) || SLEEP_CYCLES >= (1 << CNT_W) || WAKE_CYCLES >= (1 << CNT_W) ||
      STANDBY_CYCLES >= (1 << CNT_W)) begin : g_cycle_range
    $error("nvss_seq: cycle counts out of range");
  end

  localparam logic [CNT_W-1:0] RESTORE_LAST = CNT_W'(RESTORE_CYCLES - 1);
  localparam logic [CNT_W-1:0] STORE_LAST = CNT_W'(STORE_CYCLES - 1);
  localparam logic [CNT_W-1:0] RECALL_LAST = CNT_W'(RECALL_CYCLES - 1);
  localparam logic [CNT_W-1:0] SOFTSEQ_LAST = CNT_W'(SOFTSEQ_CYCLES - 1);
  localparam logic [CNT_W-1:0] SLEEP_LAST = CNT_W'(SLEEP_CYCLES - 1);
  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);
  localparam logic [CNT_W-1:0] STANDBY_LAST = CNT_W'(STANDBY_CYCLES - 1);
  localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_CYC - 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic supply_meta_reg, supply_reg;
  logic cs_meta_reg, cs_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      supply_meta_reg <= 1'b0;
      supply_reg <= 1'b0;
      cs_meta_reg <= 1'b1;
      cs_reg <= 1'b1;
    end else if (clk_en) begin
      supply_meta_reg <= supply_ok;
      supply_reg <= supply_meta_reg;
      cs_meta_reg <= cs_n;
      cs_reg <= cs_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  nvss_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg;
  nvss_op_t op_reg;
  logic pending_reg;
  logic save_en_reg;
  logic done_nv;
  logic cnt_last;
  logic [CNT_W-1:0] last_val;

  always_comb begin
    unique case (state_reg)
      NVSS_RESTORE: last_val = RESTORE_LAST;
      NVSS_SEQ: last_val = SOFTSEQ_LAST;
      NVSS_GRACE: last_val = DELAY_LAST;
      NVSS_STORE: last_val = STORE_LAST;
      NVSS_RECALL: last_val = RECALL_LAST;
      NVSS_GOSLEEP: last_val = SLEEP_LAST;
      NVSS_WAKE: last_val = WAKE_LAST;
      default: last_val = '0;
    endcase
  end
  assign cnt_last = (cnt_reg == last_val);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      NVSS_RESTORE: if (cnt_last) state_next = NVSS_READY;
      NVSS_READY: begin
        if (!supply_reg) begin
          if (save_en_reg && pending_reg) state_next = NVSS_GRACE;
          else state_next = NVSS_POWERDN;
        end else if (cmd.valid && cmd.op != NVSS_OP_NONE && cmd.op != NVSS_OP_AUTO) begin
          state_next = NVSS_SEQ;
        end
      end
      NVSS_SEQ: if (cnt_last) state_next = NVSS_GRACE;
      NVSS_GRACE: begin
        if (cnt_last) begin
          unique case (op_reg)
            NVSS_OP_STORE, NVSS_OP_AUTO: state_next = NVSS_STORE;
            NVSS_OP_RECALL: state_next = NVSS_RECALL;
            NVSS_OP_SLEEP: state_next = pending_reg ? NVSS_STORE : NVSS_GOSLEEP;
            default: state_next = NVSS_READY;
          endcase
        end
      end
      NVSS_STORE: begin
        if (cnt_last) begin
          if (op_reg == NVSS_OP_AUTO) state_next = NVSS_POWERDN;
          else if (op_reg == NVSS_OP_SLEEP) state_next = NVSS_GOSLEEP;
          else state_next = NVSS_READY;
        end
      end
      NVSS_RECALL: if (cnt_last) state_next = NVSS_READY;
      NVSS_GOSLEEP: if (cnt_last) state_next = NVSS_SLEEP;
      NVSS_SLEEP: if (!cs_reg) state_next = NVSS_WAKE;
      NVSS_WAKE: if (cnt_last) state_next = NVSS_READY;
      NVSS_POWERDN: if (supply_reg) state_next = NVSS_RESTORE;
      default: state_next = NVSS_RESTORE;
    endcase
    // supply loss cuts any activity except the power loss save (grace and store of NVSS_OP_AUTO) short
    if (!supply_reg && state_reg != NVSS_READY && state_reg != NVSS_POWERDN &&
        !(op_reg == NVSS_OP_AUTO && (state_reg == NVSS_GRACE || state_reg == NVSS_STORE))) begin
      state_next = NVSS_POWERDN;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= NVSS_POWERDN;
      cnt_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg) ? '0 : cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      op_reg <= NVSS_OP_NONE;
    end else if (clk_en && state_reg == NVSS_READY) begin
      if (!supply_reg) op_reg <= NVSS_OP_AUTO;
      else if (cmd.valid) op_reg <= cmd.op;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      save_en_reg <= SAVE_DEFAULT;
    end else if (clk_en && state_reg == NVSS_GRACE && cnt_last) begin
      if (op_reg == NVSS_OP_SAVE_EN) save_en_reg <= 1'b1;
      else if (op_reg == NVSS_OP_SAVE_DIS) save_en_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pending write, access and busy
  // ----------------------------------------------------------------
  assign done_nv = cnt_last && (state_reg == NVSS_STORE || state_reg == NVSS_RECALL || state_reg == NVSS_RESTORE);

  // write wins over a completing cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pending_reg <= 1'b0;
    end else if (clk_en) begin
      if (sram_write && sram_enable) pending_reg <= 1'b1;
      else if (done_nv) pending_reg <= 1'b0;
    end
  end

  logic [CNT_W-1:0] sb_cnt_reg;
  logic standby_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sb_cnt_reg <= '0;
      standby_reg <= 1'b0;
    end else if (clk_en) begin
      if (!cs_reg) begin
        sb_cnt_reg <= '0;
        standby_reg <= 1'b0;
      end else if (sb_cnt_reg == STANDBY_LAST) begin
        standby_reg <= 1'b1;
      end else begin
        sb_cnt_reg <= sb_cnt_reg + 1'b1;
      end
    end
  end

  logic inhibit;
  assign inhibit = !supply_reg || !(state_reg == NVSS_READY || state_reg == NVSS_SEQ ||
                                    state_reg == NVSS_GRACE);
  // grace window keeps access open so a write in flight lands
  assign sram_enable = !inhibit || (state_reg == NVSS_GRACE && op_reg == NVSS_OP_AUTO);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      store_active <= 1'b0;
      recall_active <= 1'b0;
      stat <= '0;
    end else if (clk_en) begin
      store_active <= (state_next == NVSS_STORE);
      recall_active <= (state_next == NVSS_RECALL || state_next == NVSS_RESTORE);
      stat.busy <= !(state_next == NVSS_READY || state_next == NVSS_SLEEP ||
                     state_next == NVSS_POWERDN);
      stat.access_inhibit_flag <= (state_next != NVSS_READY);
      stat.write_pending <= pending_reg;
      stat.power_loss_save <= save_en_reg;
      stat.asleep <= (state_next == NVSS_SLEEP);
      stat.standby <= standby_reg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  restore_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == NVSS_RESTORE && clk_en) |-> cnt_reg <= RESTORE_LAST)
    else $error("restore too long");
  save_trigger_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && state_reg == NVSS_READY && !supply_reg && save_en_reg && pending_reg) |=> state_reg == NVSS_GRACE)
    else $error("power loss save not started");
  save_skip_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && state_reg == NVSS_READY && !supply_reg && !pending_reg) |=> state_reg == NVSS_POWERDN)
    else $error("save not skipped");
  grace_open_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == NVSS_GRACE && supply_reg) |-> sram_enable)
    else $error("access closed in grace");
  inhibit_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == NVSS_STORE || state_reg == NVSS_RECALL) |-> !sram_enable)
    else $error("access during nv cycle");
  store_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == NVSS_STORE) |-> cnt_reg <= STORE_LAST)
    else $error("store too long");
  softseq_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == NVSS_SEQ) |-> cnt_reg <= SOFTSEQ_LAST)
    else $error("soft sequence too long");
  pending_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && done_nv && !sram_write) |=> !pending_reg)
    else $error("pending not cleared");
  busy_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && state_reg == NVSS_STORE && !cnt_last) |=> stat.busy)
    else $error("busy missing during store");
  standby_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && cs_reg && sb_cnt_reg == STANDBY_LAST) |=> standby_reg)
    else $error("standby not reached");
  recall_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == NVSS_RECALL) |-> cnt_reg <= RECALL_LAST)
    else $error("recall too long");
  grace_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == NVSS_GRACE) |-> cnt_reg <= DELAY_LAST)
    else $error("grace too long");
  sleep_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == NVSS_GOSLEEP) |-> cnt_reg <= SLEEP_LAST)
    else $error("sleep entry too long");
  wake_bound_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == NVSS_WAKE) |-> cnt_reg <= WAKE_LAST)
    else $error("wake too long");
  low_supply_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!supply_reg && !(state_reg == NVSS_GRACE && op_reg == NVSS_OP_AUTO)) |-> !sram_enable)
    else $error("access while supply low");
  restore_block_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == NVSS_RESTORE) |-> !sram_enable)
    else $error("access during restore");
  save_store_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && state_reg == NVSS_GRACE && cnt_last && op_reg == NVSS_OP_AUTO) |=> state_reg == NVSS_STORE)
    else $error("power loss store not entered");
  store_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && state_next == NVSS_STORE) |=> store_active)
    else $error("store flag missing");
  cmd_busy_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && state_reg == NVSS_READY && supply_reg && cmd.valid &&
     cmd.op != NVSS_OP_NONE && cmd.op != NVSS_OP_AUTO) |=> stat.busy)
    else $error("busy missing after command");
  idle_busy_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && state_next == NVSS_READY) |=> !stat.busy)
    else $error("busy stuck when ready");
  pending_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && sram_write && sram_enable) |=> pending_reg)
    else $error("pending not set");
  asleep_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && state_next == NVSS_SLEEP) |=> stat.asleep)
    else $error("asleep flag missing");
  wake_start_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && state_reg == NVSS_SLEEP && supply_reg && !cs_reg) |=> state_reg == NVSS_WAKE)
    else $error("wake not started");
  standby_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clk_en && !cs_reg) |=> !standby_reg)
    else $error("standby not cleared");
  freeze_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!clk_en) |=> ($stable(state_reg) && $stable(cnt_reg)))
    else $error("state moved while frozen");
endmodule // nvss_seq
